// ===== design/pzs_pkg.sv
// Purpose: Shared constants and types for the power-zone phase-shedding block.
// Assumes: 200 MHz core clock; 8-bit register port with one-cycle read data.
// Notes:   Register offsets are byte indexes on the plain register port.
package pzs_pkg;

  // Clock and timing.
  localparam int CLOCK_MHZ        = 200;
  localparam int SHED_TICK_US     = 10;
  localparam int SHED_DELAY_US    = 200;
  localparam int TICK_CYCLES      = SHED_TICK_US * CLOCK_MHZ;
  localparam int TIMER_W          = 20;
  localparam logic [7:0] SHED_DELAY_RESET = 8'(SHED_DELAY_US / SHED_TICK_US);

  // Register offsets.
  localparam logic [7:0] OFS_SHED_DELAY = 8'h00;
  localparam logic [7:0] OFS_HYST       = 8'h01;
  localparam logic [7:0] OFS_TH1        = 8'h02;
  localparam logic [7:0] OFS_TH2        = 8'h03;
  localparam logic [7:0] OFS_TH3        = 8'h04;
  localparam logic [7:0] OFS_TH4        = 8'h05;
  localparam logic [7:0] OFS_LOW_ZONE   = 8'h06;
  localparam logic [7:0] OFS_STATUS     = 8'h07;

  // Reset values and the threshold-disabled code.
  localparam logic [7:0] HYST_RESET     = 8'h10;
  localparam logic [7:0] TH1_RESET      = 8'h20;
  localparam logic [7:0] TH2_RESET      = 8'h40;
  localparam logic [7:0] TH3_RESET      = 8'h60;
  localparam logic [7:0] TH4_RESET      = 8'h80;
  localparam logic [7:0] TH_DISABLED    = 8'hFF;
  localparam logic [2:0] LOW_ZONE_RESET = 3'h0;

  // Status fields.
  localparam int ST_ZONE_LSB   = 0;
  localparam int ST_TARGET_LSB = 3;
  localparam int ST_DCM_BIT    = 6;
  localparam int ST_NOM_BIT    = 7;

  // Phase masks, phase 1 in bit 0.
  localparam logic [7:0] MASK_Z1_8PH = 8'h55;
  localparam logic [7:0] MASK_Z2_8PH = 8'h11;
  localparam logic [7:0] MASK_Z2_6PH = 8'h15;
  localparam logic [7:0] MASK_Z2_4PH = 8'h05;
  localparam logic [7:0] MASK_SINGLE = 8'h01;

  localparam logic [2:0] ZONE_DCM = 3'h4;

  typedef enum logic [1:0] {PS_LOW = 2'h0, PS_MID = 2'h1, PS_HIGH = 2'h2} pzs_ps_type;
  typedef enum logic [1:0] {ST_IDLE, ST_RISE, ST_SHED} pzs_state_type;

endpackage

// ===== design/pzs_zone_ctrl.sv
// Purpose: Power-zone selection, zone stepping and phase gating of eight PWM outputs.
// Assumes: Inputs are synchronous to CLOCK; thresholds satisfy th4 > th3 > th2 > th1.
// Notes:   The current level is compared on every clock rather than at a slower sample rate.
// What this block does
// - Power-save low holds fixed zone from low-phase setting; unsupported zone becomes 0.
// - Power-save mid picks zone from current versus four thresholds; unsupported zones are skipped.
// - Zone 4 flags discontinuous mode on DCM_MODE; zones 0 to 3 continuous.
// - Eight phases: zone0 all, zone1 odd phases, zone2 phases 1 and 5, else phase 1.
// - Other counts: zone0 all, zone2 six/four-phase subsets, zones 3-4 phase 1.
// - Rising current toward lower zone starts moving at once without shed delay.
// - Falling current toward higher zone waits programmable shed delay, default 200 us.
// - Shed delay is programmed in steps of ten microseconds.
// - Zones change one enabled step at a time, delay inserted at every step.
// - Lower zone chosen as soon as current exceeds the relevant threshold.
// - Higher zone only when current falls below threshold minus hysteresis.
// - Hysteresis defaults to sixteen counts and is software writable.
// - Stepping skips zones whose threshold is disabled.
// - Fixed mode zone changes use the same stepping, delay and skipping.
// - Fixed mode target disabled for auto shedding is enabled temporarily.
// - Back in automatic mode such a zone counts as disabled again.
// - Power-save high keeps all configured phases in zone 0.
// - After enable, power-save changes and power-save mid shedding wait for nominal output; power-save low steps to its fixed zone without waiting.
// - A threshold of all ones disables the threshold and its zone.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pzs_zone_ctrl
#(
  parameter int PHASES = 8
)
(
  input  wire logic                 CLOCK,
  input  wire logic                 ARST_N,
  input  wire logic                 ENABLE,
  input  wire logic                 OUTPUT_NOMINAL,
  input  wire pzs_pkg::pzs_ps_type  POWER_SAVE_SELECT,
  input  wire logic [3:0]           PHASE_COUNT,
  input  wire logic [7:0]           TOTAL_CURRENT_LEVEL,
  input  wire logic [PHASES-1:0]    PWM_IN,
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA,
  output logic      [PHASES-1:0]    PHASE_PWM_OUT,
  output logic      [2:0]           CURRENT_ZONE,
  output logic                      DCM_MODE
);
  import pzs_pkg::*;

  typedef struct packed {
    logic [2:0]           zone;
    pzs_state_type        state;
    logic [TIMER_W-1:0]   timer;
    pzs_ps_type           mode_cap;
    logic                 nominal_seen;
    logic [7:0]           shed_delay;
    logic [7:0]           hyst;
    logic [3:0][7:0]      th;
    logic [2:0]           low_zone;
    logic [7:0]           rdata;
    logic [PHASES-1:0]    pwm;
  } pzs_regs_type;
  pzs_regs_type s_reg;
  pzs_regs_type s_next;
  function automatic logic zone_sup(input logic [2:0] z, input logic [3:0] n);
    case (z)
      3'h0, 3'h4: zone_sup = 1'b1;
      3'h3:       zone_sup = (n >= 4'h2);
      3'h2:       zone_sup = (n == 4'h8) || (n == 4'h6) || (n == 4'h4);
      3'h1:       zone_sup = (n == 4'h8);
      default:    zone_sup = 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] zone_mask(input logic [2:0] z, input logic [3:0] n);
    case (z)
      3'h0:    zone_mask = 8'((9'h001 << n) - 9'h001);
      3'h1:    zone_mask = MASK_Z1_8PH;
      3'h2:    zone_mask = (n == 4'h8) ? MASK_Z2_8PH : (n == 4'h6) ? MASK_Z2_6PH : MASK_Z2_4PH;
      default: zone_mask = MASK_SINGLE;
    endcase
  endfunction
  // Threshold tied to zone z: zone 4 uses th1, zone 1 uses th4.
  function automatic logic [7:0] zone_th(input logic [3:0][7:0] th, input logic [2:0] z);
    zone_th = th[2'(3'h4 - z)];
  endfunction
  // Next enabled zone on the way to t; t itself always counts as reachable.
  function automatic logic [2:0] step_toward(input logic [2:0] c, input logic [2:0] t,
                                             input logic [4:0] en);
    step_toward = t;
    if (t < c)
    begin
      for (int z = 0; z < 5; z++)
        if (3'(z) < c && 3'(z) > t && en[z])
          step_toward = 3'(z);
    end
    else
    begin
      for (int z = 4; z >= 0; z--)
        if (3'(z) > c && 3'(z) < t && en[z])
          step_toward = 3'(z);
    end
  endfunction

  function automatic logic [2:0] auto_target(input logic [2:0] c, input logic [7:0] i,
                                             input logic [3:0][7:0] th, input logic [7:0] hy,
                                             input logic [4:0] en);
    logic ok;
    ok = 1'b1;
    auto_target = c;
    if (c != 3'h0 && en[c] && i > zone_th(th, c))
    begin
      auto_target = 3'h0;
      for (int z = 1; z < 4; z++)
        if (3'(z) < c && en[z] && i <= zone_th(th, 3'(z)))
          auto_target = 3'(z);
    end
    else
    begin
      for (int z = 1; z < 5; z++)
        if (3'(z) > c && en[z])
        begin
          if (ok && ({1'b0, i} + {1'b0, hy}) < {1'b0, zone_th(th, 3'(z))})
            auto_target = 3'(z);
          else
            ok = 1'b0;
        end
    end
  endfunction

  pzs_ps_type         eff_mode;
  logic               auto_on;
  logic [4:0]         en_auto;
  logic [4:0]         en_step;
  logic [2:0]         target;
  logic [TIMER_W-1:0] delay_cycles;
  logic [2:0]         step;

  always_comb
  begin
    delay_cycles = TIMER_W'(s_reg.shed_delay) * TIMER_W'(TICK_CYCLES);
    eff_mode = s_reg.nominal_seen ? POWER_SAVE_SELECT : s_reg.mode_cap;
    auto_on  = (eff_mode == PS_MID) && s_reg.nominal_seen;
    for (int z = 0; z < 5; z++)
      en_auto[z] = zone_sup(3'(z), PHASE_COUNT) &&
                   (z == 0 || zone_th(s_reg.th, 3'(z)) != TH_DISABLED);
    case (eff_mode)
      PS_LOW:  target = zone_sup(s_reg.low_zone, PHASE_COUNT) ? s_reg.low_zone : 3'h0;
      PS_MID:  target = auto_on ? auto_target(s_reg.zone, TOTAL_CURRENT_LEVEL, s_reg.th,
                                              s_reg.hyst, en_auto) : 3'h0;
      default: target = 3'h0;
    endcase
    en_step = en_auto;
    if (eff_mode == PS_LOW)
      en_step[target] = 1'b1;
    step = step_toward(s_reg.zone, target, en_step);
  end

  always_comb
  begin
    s_next = s_reg;
    if (!ENABLE)
    begin
      s_next.zone         = 3'h0;
      s_next.state        = ST_IDLE;
      s_next.timer        = '0;
      s_next.nominal_seen = 1'b0;
      s_next.mode_cap     = POWER_SAVE_SELECT;
    end
    else
    begin
      if (OUTPUT_NOMINAL)
        s_next.nominal_seen = 1'b1;
      case (s_reg.state)
        ST_IDLE:
        begin
          if (target < s_reg.zone)
          begin
            s_next.zone  = step;
            s_next.state = ST_RISE;
            s_next.timer = delay_cycles;
          end
          else if (target > s_reg.zone)
          begin
            s_next.state = ST_SHED;
            s_next.timer = delay_cycles;
          end
        end
        ST_RISE:
        begin
          if (s_reg.timer != '0)
            s_next.timer = s_reg.timer - 1'b1;
          else if (target < s_reg.zone)
          begin
            s_next.zone  = step;
            s_next.timer = delay_cycles;
          end
          else if (target > s_reg.zone)
          begin
            s_next.state = ST_SHED;
            s_next.timer = delay_cycles;
          end
          else
            s_next.state = ST_IDLE;
        end
        ST_SHED:
        begin
          if (target < s_reg.zone)
          begin
            s_next.zone  = step;
            s_next.state = ST_RISE;
            s_next.timer = delay_cycles;
          end
          else if (target == s_reg.zone)
            s_next.state = ST_IDLE;
          else if (s_reg.timer != '0)
            s_next.timer = s_reg.timer - 1'b1;
          else
          begin
            s_next.zone  = step;
            s_next.timer = delay_cycles;
          end
        end
        default:
          s_next.state = ST_IDLE;
      endcase
    end
    if (REG_WR)
    begin
      case (REG_ADDR)
        OFS_SHED_DELAY: s_next.shed_delay = REG_WDATA;
        OFS_HYST:       s_next.hyst       = REG_WDATA;
        OFS_TH1:        s_next.th[0]      = REG_WDATA;
        OFS_TH2:        s_next.th[1]      = REG_WDATA;
        OFS_TH3:        s_next.th[2]      = REG_WDATA;
        OFS_TH4:        s_next.th[3]      = REG_WDATA;
        OFS_LOW_ZONE:   s_next.low_zone   = REG_WDATA[2:0];
        default:        s_next.low_zone   = s_reg.low_zone;
      endcase
    end
    s_next.rdata = 8'h00;
    if (REG_RD)
    begin
      case (REG_ADDR)
        OFS_SHED_DELAY: s_next.rdata = s_reg.shed_delay;
        OFS_HYST:       s_next.rdata = s_reg.hyst;
        OFS_TH1:        s_next.rdata = s_reg.th[0];
        OFS_TH2:        s_next.rdata = s_reg.th[1];
        OFS_TH3:        s_next.rdata = s_reg.th[2];
        OFS_TH4:        s_next.rdata = s_reg.th[3];
        OFS_LOW_ZONE:   s_next.rdata = {5'h00, s_reg.low_zone};
        OFS_STATUS:
        begin
          s_next.rdata[ST_ZONE_LSB +: 3]   = s_reg.zone;
          s_next.rdata[ST_TARGET_LSB +: 3] = target;
          s_next.rdata[ST_DCM_BIT]         = (s_reg.zone == ZONE_DCM);
          s_next.rdata[ST_NOM_BIT]         = s_reg.nominal_seen;
        end
        default:        s_next.rdata = 8'h00;
      endcase
    end
    s_next.pwm = PWM_IN & PHASES'(zone_mask(s_reg.zone, PHASE_COUNT));
  end

  // Gating is registered so a phase never glitches on a zone change mid-cycle.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_reg            <= '0;
      s_reg.state      <= ST_IDLE;
      s_reg.mode_cap   <= PS_HIGH;
      s_reg.shed_delay <= SHED_DELAY_RESET;
      s_reg.hyst       <= HYST_RESET;
      s_reg.th         <= {TH4_RESET, TH3_RESET, TH2_RESET, TH1_RESET};
      s_reg.low_zone   <= LOW_ZONE_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign REG_RDATA     = s_reg.rdata;
  assign PHASE_PWM_OUT = s_reg.pwm;
  assign CURRENT_ZONE  = s_reg.zone;
  assign DCM_MODE      = (s_reg.zone == ZONE_DCM);

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  property p_mask8_z1;
    (PHASE_COUNT == 4'h8 && s_reg.zone == 3'h1) |=>
      PHASE_PWM_OUT == ($past(PWM_IN) & PHASES'(MASK_Z1_8PH));
  endproperty
  a_mask8_z1: assert property (p_mask8_z1) else $error("zone 1 eight-phase mask wrong");
  property p_mask6_z2;
    (PHASE_COUNT == 4'h6 && s_reg.zone == 3'h2) |=>
      PHASE_PWM_OUT == ($past(PWM_IN) & PHASES'(MASK_Z2_6PH));
  endproperty
  a_mask6_z2: assert property (p_mask6_z2) else $error("zone 2 six-phase mask wrong");
  property p_dcm;
    DCM_MODE |-> CURRENT_ZONE == ZONE_DCM && PHASE_COUNT != 4'h0;
  endproperty
  a_dcm: assert property (p_dcm) else $error("discontinuous mode outside zone 4");
  property p_rise_now;
    (ENABLE && s_reg.state == ST_IDLE && target < s_reg.zone) |=> CURRENT_ZONE < $past(CURRENT_ZONE);
  endproperty
  a_rise_now: assert property (p_rise_now) else $error("rising step not taken at once");
  property p_shed_wait;
    (ENABLE && s_reg.zone > $past(s_reg.zone)) |-> $past(s_reg.state == ST_SHED && s_reg.timer == '0);
  endproperty
  a_shed_wait: assert property (p_shed_wait) else $error("shed step before delay expired");
  property p_step_hold;
    (ENABLE && s_reg.state == ST_RISE && s_reg.timer != '0 && s_reg.shed_delay != 8'h00) |=>
      CURRENT_ZONE == $past(CURRENT_ZONE);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("zone stepped inside step delay");
  property p_cancel;
    (ENABLE && s_reg.state == ST_SHED && target < s_reg.zone) |=> s_reg.state == ST_RISE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending shed not cancelled");
  property p_high_zero;
    (ENABLE && eff_mode == PS_HIGH && s_reg.zone == 3'h0) |=> CURRENT_ZONE == 3'h0 ##1 CURRENT_ZONE == 3'h0 || !ENABLE || eff_mode != PS_HIGH;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("zone left 0 with power-save high");
  property p_no_auto_early;
    (ENABLE && !s_reg.nominal_seen && s_reg.mode_cap == PS_MID && s_reg.zone == 3'h0) |=> CURRENT_ZONE == 3'h0;
  endproperty
  a_no_auto_early: assert property (p_no_auto_early) else $error("shedding before nominal output");
  property p_auto_enabled;
    (auto_on && $changed(s_reg.zone) && $past(auto_on)) |-> en_auto[s_reg.zone];
  endproperty
  a_auto_enabled: assert property (p_auto_enabled) else $error("disabled zone entered in auto mode");
  c_zone4:  cover property (ENABLE && CURRENT_ZONE == ZONE_DCM);
  c_shed:   cover property (s_reg.state == ST_SHED && s_reg.timer == '0 && target > s_reg.zone);
  c_cancel: cover property (s_reg.state == ST_SHED && target < s_reg.zone);
  c_fixed:  cover property (eff_mode == PS_LOW && !en_auto[target]);

endmodule
`default_nettype wire

// ===== tb/pzs_host_model.sv
// Purpose: Host-side model that drives the three-level power-save select input.
// Assumes: Level requests from the bench arrive synchronous to the clock.
// Notes:   The host only ever shows the three legal levels, never the spare code.
`timescale 1ns/1ps
`default_nettype none
module pzs_host_model
(
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire pzs_pkg::pzs_ps_type mode_req,
  output var  pzs_pkg::pzs_ps_type power_save_select
);
  import pzs_pkg::*;

  // The level is registered so it changes just after an edge, like a real pin driver.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      power_save_select <= PS_MID;
    else if (mode_req == PS_LOW || mode_req == PS_MID)
      power_save_select <= mode_req;
    else
      power_save_select <= PS_HIGH;
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for zone selection, stepping and phase gating.
// Assumes: Shed delay register set to 1, so one delay is 2000 clock cycles.
// Notes:   Step timing is checked against a small window around the delay.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import pzs_pkg::*;

  logic             clock;
  logic             arst_n;
  logic             enable;
  logic             nominal;
  pzs_ps_type       ps_req;
  pzs_ps_type       ps_pin;
  logic [3:0]       phase_count;
  logic [7:0]       current;
  logic [7:0]       pwm_in;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic [7:0]       pwm_out;
  logic [2:0]       zone;
  logic             dcm;
  logic [7:0]       rd;
  logic             seen_two;
  logic             clr_seen;
  int               fail_count;
  int               tests_run;
  int               cyc;

  pzs_host_model host (.clock(clock), .arst_n(arst_n), .mode_req(ps_req),
    .power_save_select(ps_pin));

  pzs_zone_ctrl #(.PHASES(8)) dut (.CLOCK(clock), .ARST_N(arst_n), .ENABLE(enable),
    .OUTPUT_NOMINAL(nominal), .POWER_SAVE_SELECT(ps_pin), .PHASE_COUNT(phase_count),
    .TOTAL_CURRENT_LEVEL(current), .PWM_IN(pwm_in), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .PHASE_PWM_OUT(pwm_out), .CURRENT_ZONE(zone), .DCM_MODE(dcm));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe, so sample just inside it.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic wait_zone(input logic [2:0] z, input int lo, input int hi);
    int n;
    n = 0;
    // The zone is read just after each edge so the value launched by that edge is seen.
    #1;
    while (zone !== z && n <= hi)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("zone", z, zone)
    `CHK("zone step time", 1'b1, (n >= lo && n <= hi))
    @(posedge clock);
  endtask

  task automatic chk_out(input logic [2:0] z, input logic [7:0] mask);
    repeat (2) @(posedge clock);
    #1;
    `CHK("phase outputs", mask & pwm_in, pwm_out)
    `CHK("dcm flag", (z == ZONE_DCM), dcm)
    @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    seen_two <= (seen_two || zone === 3'h2) && !clr_seen;
    cyc++;
    if (cyc == 95000)
    begin
      fail_count++;
      conclude();
    end
  end

  initial
  begin
    logic [7:0] exp_reset [0:6];
    exp_reset = '{SHED_DELAY_RESET, HYST_RESET, TH1_RESET, TH2_RESET, TH3_RESET,
                  TH4_RESET, 8'h00};
    arst_n = 1'b0; enable = 1'b0; nominal = 1'b0; ps_req = PS_MID;
    phase_count = 4'h8; current = 8'h00; pwm_in = 8'hFF; reg_addr = 8'h00;
    reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    fail_count = 0; tests_run = 0; clr_seen = 1'b1;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 7; i++)
    begin
      reg_read(8'(i), rd);
      `CHK("register reset value", exp_reset[i], rd)
    end
    reg_read(8'h08, rd);
    `CHK("unmapped read", 8'h00, rd)
    reg_write(OFS_SHED_DELAY, 8'h01);
    reg_read(OFS_SHED_DELAY, rd);
    `CHK("shed delay", 8'h01, rd)
    enable <= 1'b1;
    repeat (2600) @(posedge clock);
    `CHK("zone before nominal", 3'h0, zone)
    nominal <= 1'b1;
    for (int z = 1; z <= 4; z++)
    begin
      wait_zone(3'(z), 1990, 2010);
      chk_out(3'(z), (z == 1) ? MASK_Z1_8PH : (z == 2) ? MASK_Z2_8PH : MASK_SINGLE);
    end
    current <= 8'hFF;
    wait_zone(3'h3, 0, 3);
    wait_zone(3'h2, 1990, 2010);
    wait_zone(3'h1, 1990, 2010);
    wait_zone(3'h0, 1990, 2010);
    chk_out(3'h0, 8'hFF);
    current <= 8'h78;
    repeat (2600) @(posedge clock);
    `CHK("zone inside hysteresis", 3'h0, zone)
    current <= 8'h6F;
    wait_zone(3'h1, 1990, 2010);
    reg_write(OFS_TH3, TH_DISABLED);
    current <= 8'h50;
    repeat (2600) @(posedge clock);
    `CHK("disabled zone not chosen", 3'h1, zone)
    clr_seen <= 1'b0;
    current <= 8'h00;
    wait_zone(3'h3, 1990, 2010);
    `CHK("disabled zone skipped", 1'b0, seen_two)
    wait_zone(3'h4, 1990, 2010);
    reg_write(OFS_LOW_ZONE, 8'h02);
    ps_req <= PS_LOW;
    wait_zone(3'h3, 0, 6);
    wait_zone(3'h2, 1990, 2010);
    chk_out(3'h2, MASK_Z2_8PH);
    ps_req <= PS_HIGH;
    wait_zone(3'h0, 0, 4100);
    chk_out(3'h0, 8'hFF);
    phase_count <= 4'h4;
    chk_out(3'h0, 8'h0F);
    ps_req <= PS_LOW;
    wait_zone(3'h2, 0, 4100);
    chk_out(3'h2, MASK_Z2_4PH);
    reg_write(OFS_LOW_ZONE, 8'h01);
    wait_zone(3'h0, 0, 4100);
    chk_out(3'h0, 8'h0F);
    conclude();
  end
endmodule
`default_nettype wire
